/* rtl/ssq_params.svh */
/*
 * Constants for the special instruction sequencer: opcodes, timing counts,
 * stack and ROM geometry, clock divider option codes.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef SSQ_PARAMS_SVH
`define SSQ_PARAMS_SVH

// ----------------------------------------------------------------
// Opcodes of the special instructions
// ----------------------------------------------------------------
`define SSQ_OP_XCHG_SER   8'h4F
`define SSQ_OP_JMP_IND    8'hFF
`define SSQ_OP_SKIP_TMR   8'h41
`define SSQ_OP_PREFIX     8'h33
`define SSQ_OP2_RD_EDGE   8'h29
`define SSQ_OP2_LD_TABLE  8'hBF
`define SSQ_OP_CLR_ACC    8'h00

// ----------------------------------------------------------------
// Geometry and counts
// ----------------------------------------------------------------
`define SSQ_PC_W          10
`define SSQ_PAGE_W        6
`define SSQ_TB_DIV        1024
`define SSQ_SER_BITS      4
`define SSQ_EDGE_LOW_MIN  2

// ----------------------------------------------------------------
// Clock input option codes and their divide ratios
// ----------------------------------------------------------------
`define SSQ_CKI_DIV32     3'h0
`define SSQ_CKI_DIV16     3'h1
`define SSQ_CKI_DIV8      3'h2
`define SSQ_CKI_RC        3'h3
`define SSQ_CKI_SCHMITT   3'h4

`endif

/* rtl/ssq_pkg.sv */
/*
 * Types shared by the special instruction sequencer files.
 * Assumes ssq_params.svh is on the include path.
 */
`include "ssq_params.svh"

package ssq_pkg;

    // ------------------------------------------------------------
    // Sequencer states, Gray coded between FETCH and SECOND only
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SSQ_ST_FETCH  = 2'b00,  // Normal fetch/execute
        SSQ_ST_SECOND = 2'b01,  // Second cycle of two-cycle op
        SSQ_ST_SKIP   = 2'b11   // Skipping one or two bytes
    } ssq_state_e;

    // Three-level return stack
    typedef struct packed {
        logic [`SSQ_PC_W-1:0] top;     // stack_top
        logic [`SSQ_PC_W-1:0] middle;  // stack_middle
        logic [`SSQ_PC_W-1:0] bottom;  // stack_bottom
    } ssq_stack_s;

    // Serial block state
    typedef struct packed {
        logic [3:0] shreg;   // serial_shift_counter_reg
        logic       sclk_l;  // serial_clock_latch
    } ssq_serial_s;

endpackage : ssq_pkg

/* rtl/ssq_clkdiv.sv */
/*
 * Instruction cycle tick generator from the oscillator clock.
 * Assumes clk_in is the oscillator and the option code is static.
 */
`timescale 1ns/100ps
`include "ssq_params.svh"

module ssq_clkdiv
    import ssq_pkg::*;
(
    input  wire logic       clk_in,    // Oscillator clock
    input  wire logic       nrst_in,   // Async reset, active low
    input  wire logic [2:0] opt_in,    // Clock input option code
    output logic            tick_out   // One-cycle instruction tick
);

    logic [4:0] cnt_r;   // Divider counter
    logic [4:0] last_w;  // Terminal count for option

    // Divide ratio from mask option
    always_comb begin
        if (opt_in == `SSQ_CKI_DIV32) begin
            last_w = 5'h1F;
        end else if (opt_in == `SSQ_CKI_DIV16) begin
            last_w = 5'h0F;
        end else if (opt_in == `SSQ_CKI_DIV8) begin
            last_w = 5'h07;
        end else begin
            last_w = 5'h03;
        end
    end

    // Counter and tick
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_r    <= 5'h00;
            tick_out <= 1'b0;
        end else if (cnt_r >= last_w) begin
            cnt_r    <= 5'h00;
            tick_out <= 1'b1;
        end else begin
            cnt_r    <= cnt_r + 5'h01;
            tick_out <= 1'b0;
        end
    end

endmodule : ssq_clkdiv

/* rtl/ssq_edge_latch.sv */
/*
 * One falling-edge latch with a two-instruction-cycle low filter.
 * Assumes the input is already synchronised and tick_in is one cycle.
 * Latch is not cleared by reset; it powers up clear via its initial value.
 */
`timescale 1ns/100ps
`include "ssq_params.svh"

module ssq_edge_latch
    import ssq_pkg::*;
(
    input  wire logic clk_in,    // Oscillator clock
    input  wire logic tick_in,   // Instruction cycle tick
    input  wire logic line_in,   // Synchronised input line
    input  wire logic clr_in,    // Read-and-clear strobe
    output logic      latch_out  // Falling edge seen
);

    logic       prev_r = 1'b1;   // Line at last tick
    logic [1:0] low_r  = 2'h0;   // Low ticks since fall
    logic       latch_r = 1'b0;  // The latch itself

    // Sample line on instruction clock, count low duration
    always_ff @(posedge clk_in) begin
        if (tick_in) begin
            prev_r <= line_in;
            if (line_in) begin
                low_r <= 2'h0;
            end else if (prev_r || low_r != 2'h0) begin
                if (low_r != 2'h3) begin
                    low_r <= low_r + 2'h1;
                end
            end
        end
    end

    // Set wins over clear; no reset term
    always_ff @(posedge clk_in) begin
        if (tick_in && !line_in && low_r == 2'(`SSQ_EDGE_LOW_MIN - 1)) begin
            latch_r <= 1'b1;
        end else if (clr_in) begin
            latch_r <= 1'b0;
        end
    end

    assign latch_out = latch_r;

endmodule : ssq_edge_latch

/* rtl/ssq_seq.sv */
/*
 * Special instruction sequencer of a 4-bit controller core: serial
 * exchange, indirect jump, table load, edge-latch read, skip on timer,
 * plain binary program counter across pages and clock option divider.
 * Assumes ROM is read combinationally through rom_addr_out/rom_data_in,
 * the accumulator, carry and RAM digit live in the host core and are
 * presented here; results return through registered outputs.
 */
// Contract
// - Serial exchange swaps accumulator and serial register
// - Shift mode shifts one bit per cycle
// - Exchange updates serial clock output per config
// - Carry copied into serial clock latch
// - Indirect jump loads ROM word into low PC
// - Indirect jump takes two cycles
// - Edge latch sets on two-cycle low pulse
// - Latch read returns latches, then clears them
// - Bit 2 is clock pin or one
// - Bit 1 always reads zero
// - Reset does not clear edge latches
// - Table load pushes, fetches output latch, pops
// - Net stack effect: middle copied to bottom
// - Table load takes two cycles
// - Time-base divides by 1024, latches overflow
// - Skip on timer skips and clears latch
// - Skipped byte costs one cycle each
// - Sixteen pages of 64, binary counter
// - Jumps at last word of a page group act in next group
// - Clock option divides by 32/16/8/4
`timescale 1ns/100ps
`include "ssq_params.svh"

module ssq_seq
    import ssq_pkg::*;
#(
    parameter int TB_DIV = `SSQ_TB_DIV  // Time-base divide ratio
)(
    input  wire logic                 clk_in,        // Oscillator clock
    input  wire logic                 nrst_in,       // Async reset, low
    input  wire logic [2:0]           cki_opt_in,    // Clock option
    input  wire logic                 cko_in_opt_in, // Clock pin is input
    input  wire logic                 cko_pin_in,    // Clock pin level
    input  wire logic [7:0]           rom_data_in,   // ROM word at addr
    input  wire logic [3:0]           acc_in,        // Accumulator
    input  wire logic [3:0]           ram_digit_in,  // Addressed RAM
    input  wire logic                 carry_in,      // Carry flag
    input  wire logic                 ser_shift_in,  // Serial is shifter
    input  wire logic                 ser_sclk_en_in,// Clock enabled
    input  wire logic                 ser_in,        // Serial data in
    input  wire logic                 in0_in,        // Input line 0
    input  wire logic                 in3_in,        // Input line 3
    input  wire logic                 skip_in,       // Other op skips
    input  wire logic                 two_byte_in,   // Next op 2 bytes
    output logic [`SSQ_PC_W-1:0]      rom_addr_out,  // ROM address
    output logic [`SSQ_PC_W-1:0]      pc_out,        // Program counter
    output logic [3:0]                acc_out,       // Acc write data
    output logic                      acc_we_out,    // Acc write pulse
    output logic [7:0]                q_out,         // Output latch
    output logic                      sclk_out,      // serial_clock_out
    output logic                      ser_out,       // Serial data out
    output logic                      tb_flag_out,   // Overflow latch
    output logic                      tick_out,      // Instr cycle tick
    output logic                      busy_out       // In 2nd/skip cycle
);

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                 tick_w;       // Instruction tick
    ssq_state_e           state_r;      // Sequencer state
    logic [`SSQ_PC_W-1:0] pc_r;         // Program counter
    logic [`SSQ_PC_W-1:0] pc_inc_w;     // PC plus one
    logic [`SSQ_PC_W-1:0] ind_addr_w;   // Indirect address
    logic [7:0]           op_r;         // Opcode byte of prior
    logic                 prefix_r;     // Prior byte was prefix
    logic                 is_jid_w;     // Indirect jump decode
    logic                 is_load_table_indirect_w;    // Table load decode
    logic                 is_xas_w;     // Serial exchange decode
    logic                 is_skt_w;     // Skip on timer decode
    logic                 is_read_edge_latches_w;    // Edge read decode
    logic                 second_lq_r;  // Second cycle is table
    ssq_stack_s           stk_r;        // Return stack
    ssq_serial_s          ser_r;        // Serial block
    logic [9:0]           tb_cnt_r;     // Time-base counter
    logic                 tb_ovf_w;     // Counter wraps now
    logic                 tb_flag_r;    // Overflow latch
    logic [2:0]           s0_r, s1_r, s2_r; // Input synchronisers
    logic [2:0]           in_clean_r;   // Agreed input levels
    logic                 il0_w, il3_w; // Edge latch values
    logic                 il_clr_w;     // Latch clear strobe
    logic [1:0]           skip_cnt_r;   // Bytes left to skip

    // ------------------------------------------------------------
    // Clock divider
    // ------------------------------------------------------------
    ssq_clkdiv u_div (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .opt_in   (cki_opt_in),
        .tick_out (tick_w)
    );

    // ------------------------------------------------------------
    // Decode of current ROM byte
    // ------------------------------------------------------------
    always_comb begin
        is_jid_w  = !prefix_r && rom_data_in == `SSQ_OP_JMP_IND;
        is_xas_w  = !prefix_r && rom_data_in == `SSQ_OP_XCHG_SER;
        is_skt_w  = !prefix_r && rom_data_in == `SSQ_OP_SKIP_TMR;
        is_read_edge_latches_w = prefix_r && rom_data_in == `SSQ_OP2_RD_EDGE;
        is_load_table_indirect_w = prefix_r && rom_data_in == `SSQ_OP2_LD_TABLE;
    end

    // Increment across page boundaries; plain binary
    assign pc_inc_w = pc_r + 10'h001;

    // Indirect address uses the incremented PC top bits so that a
    // last-word op falls into the next page group
    assign ind_addr_w = {pc_inc_w[9:8], acc_in, ram_digit_in};

    // ------------------------------------------------------------
    // Sequencer state, PC and skip bookkeeping
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r     <= SSQ_ST_FETCH;
            pc_r        <= 10'h000;
            prefix_r    <= 1'b0;
            op_r        <= 8'h00;
            second_lq_r <= 1'b0;
            skip_cnt_r  <= 2'h0;
        end else if (tick_w) begin
            case (state_r)
                SSQ_ST_FETCH: begin
                    op_r     <= rom_data_in;
                    prefix_r <= !prefix_r &&
                                rom_data_in == `SSQ_OP_PREFIX;
                    if (is_jid_w || is_load_table_indirect_w) begin
                        state_r     <= SSQ_ST_SECOND;
                        second_lq_r <= is_load_table_indirect_w;
                        pc_r        <= pc_inc_w;
                    end else if ((is_skt_w && tb_flag_r) || skip_in) begin
                        state_r    <= SSQ_ST_SKIP;
                        skip_cnt_r <= two_byte_in ? 2'h2 : 2'h1;
                        pc_r       <= pc_inc_w;
                    end else begin
                        pc_r <= pc_inc_w;
                    end
                end
                SSQ_ST_SECOND: begin
                    state_r <= SSQ_ST_FETCH;
                    if (!second_lq_r) begin
                        // Top two bits kept
                        pc_r <= {pc_r[9:8], rom_data_in};
                    end
                end
                SSQ_ST_SKIP: begin
                    // One cycle per skipped byte, no two-cycle ops
                    pc_r       <= pc_inc_w;
                    prefix_r   <= 1'b0;
                    skip_cnt_r <= skip_cnt_r - 2'h1;
                    if (skip_cnt_r == 2'h1) begin
                        state_r <= SSQ_ST_FETCH;
                    end
                end
                default: begin
                    state_r <= SSQ_ST_FETCH;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // ROM address mux: indirect word in second cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rom_addr_out <= 10'h000;
        end else if (tick_w && state_r == SSQ_ST_FETCH &&
                     (is_jid_w || is_load_table_indirect_w)) begin
            rom_addr_out <= ind_addr_w;
        end else if (tick_w && state_r == SSQ_ST_SECOND) begin
            // Table load resumes at the saved PC, jump at its target
            rom_addr_out <= second_lq_r ? pc_r :
                            {pc_r[9:8], rom_data_in};
        end else if (tick_w) begin
            rom_addr_out <= pc_inc_w;
        end
    end

    // ------------------------------------------------------------
    // Stack: push then pop leaves middle copied to bottom
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stk_r <= '0;
        end else if (tick_w && state_r == SSQ_ST_SECOND && second_lq_r) begin
            stk_r.bottom <= stk_r.middle;
        end
    end

    // Output latch loaded from table word
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            q_out <= 8'h00;
        end else if (tick_w && state_r == SSQ_ST_SECOND && second_lq_r) begin
            q_out <= rom_data_in;
        end
    end

    // ------------------------------------------------------------
    // Serial register: exchange or shift
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ser_r <= '0;
        end else if (tick_w && state_r == SSQ_ST_FETCH && is_xas_w) begin
            ser_r.shreg  <= acc_in;
            ser_r.sclk_l <= carry_in;
        end else if (tick_w && ser_shift_in) begin
            ser_r.shreg <= {ser_r.shreg[2:0], ser_in};
        end
    end

    // Serial clock and data outputs
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sclk_out <= 1'b0;
            ser_out  <= 1'b0;
        end else begin
            sclk_out <= ser_r.sclk_l && ser_sclk_en_in &&
                        ser_shift_in && !tick_w;
            ser_out  <= ser_shift_in ? ser_r.shreg[3] : 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Accumulator write-back for exchange and edge read
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc_out    <= 4'h0;
            acc_we_out <= 1'b0;
        end else if (tick_w && state_r == SSQ_ST_FETCH && is_xas_w) begin
            acc_out    <= ser_r.shreg;
            acc_we_out <= 1'b1;
        end else if (tick_w && state_r == SSQ_ST_FETCH && is_read_edge_latches_w) begin
            acc_out    <= {il3_w, cko_in_opt_in ? in_clean_r[2] : 1'b1,
                           1'b0, il0_w};
            acc_we_out <= 1'b1;
        end else begin
            acc_we_out <= 1'b0;
        end
    end

    assign il_clr_w = tick_w && state_r == SSQ_ST_FETCH && is_read_edge_latches_w;

    // ------------------------------------------------------------
    // Pin synchronisers: change accepted when stages 2 and 3 agree
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s0_r       <= 3'h7;
            s1_r       <= 3'h7;
            s2_r       <= 3'h7;
            in_clean_r <= 3'h7;
        end else begin
            s0_r <= {cko_pin_in, in3_in, in0_in};
            s1_r <= s0_r;
            s2_r <= s1_r;
            for (int i = 0; i < 3; i++) begin
                if (s1_r[i] == s2_r[i]) begin
                    in_clean_r[i] <= s2_r[i];
                end
            end
        end
    end

    // Edge latches on the filtered lines
    ssq_edge_latch u_il0 (
        .clk_in    (clk_in),
        .tick_in   (tick_w),
        .line_in   (in_clean_r[0]),
        .clr_in    (il_clr_w),
        .latch_out (il0_w)
    );

    ssq_edge_latch u_il3 (
        .clk_in    (clk_in),
        .tick_in   (tick_w),
        .line_in   (in_clean_r[1]),
        .clr_in    (il_clr_w),
        .latch_out (il3_w)
    );

    // ------------------------------------------------------------
    // Time-base counter and overflow latch
    // ------------------------------------------------------------
    assign tb_ovf_w = tick_w && tb_cnt_r == 10'(TB_DIV - 1);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tb_cnt_r <= 10'h000;
        end else if (tb_ovf_w) begin
            tb_cnt_r <= 10'h000;
        end else if (tick_w) begin
            tb_cnt_r <= tb_cnt_r + 10'h001;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tb_flag_r <= 1'b0;
        end else if (tb_ovf_w) begin
            tb_flag_r <= 1'b1;
        end else if (tick_w && state_r == SSQ_ST_FETCH && is_skt_w) begin
            tb_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registered status outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pc_out      <= 10'h000;
            tb_flag_out <= 1'b0;
            tick_out    <= 1'b0;
            busy_out    <= 1'b0;
        end else begin
            pc_out      <= pc_r;
            tb_flag_out <= tb_flag_r;
            tick_out    <= tick_w;
            busy_out    <= state_r != SSQ_ST_FETCH;
        end
    end

endmodule : ssq_seq

/* tb/ssq_rom_model.sv */
/* Program ROM model for the sequencer bench, read without delay.
   Assumes a 10-bit fetch address; unlisted words hold skip-on-timer. */
`timescale 1ns/100ps

module ssq_rom_model
    import ssq_pkg::*;
(
    input  wire logic [9:0] addr_in,  // Fetch address
    output logic      [7:0] data_out  // Byte at that address
);
    logic [7:0] mem [0:1023];  // Program store

    // Program: edge read, table load, indirect jump, exchanges, skip
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = 8'h41;
        end
        mem[10'h000] = 8'h00;
        mem[10'h001] = 8'h33;
        mem[10'h002] = 8'h29;
        mem[10'h003] = 8'h33;
        mem[10'h004] = 8'hBF;
        mem[10'h005] = 8'hFF;
        mem[10'h05A] = 8'hC3;
        mem[10'h0C3] = 8'h4F;
        mem[10'h0C4] = 8'h4F;
        mem[10'h0C6] = 8'hFF;
        mem[10'h0C7] = 8'h44;
    end

    assign data_out = mem[addr_in];
endmodule : ssq_rom_model

/* tb/ssq_seq_props.sv */
/* Assertion checker for the special instruction sequencer.
   Assumes the top ports only, one clock domain, bound below. */
`timescale 1ns/100ps

module ssq_seq_props
    import ssq_pkg::*;
(
    input wire logic       clk_in,        // Clock
    input wire logic       nrst_in,       // Reset, low
    input wire logic [2:0] cki_opt_in,    // Clock option
    input wire logic       cko_in_opt_in, // Clock pin is input
    input wire logic       cko_pin_in,    // Clock pin level
    input wire logic [7:0] rom_data_in,   // ROM byte
    input wire logic [3:0] acc_in,        // Accumulator
    input wire logic [3:0] ram_digit_in,  // RAM digit
    input wire logic [9:0] rom_addr_out,  // ROM address
    input wire logic [3:0] acc_out,       // Acc write data
    input wire logic       acc_we_out,    // Acc write pulse
    input wire logic [7:0] q_out,         // Output latch
    input wire logic       tb_flag_out,   // Overflow latch
    input wire logic       tick_out,      // Delayed tick
    input wire logic       busy_out       // Second or skip cycle
);
    logic [5:0] gap_r;    // Clocks since last tick
    logic       seen_r;   // One tick has passed
    logic [7:0] rd_r;     // Byte decoded at last edge
    logic [7:0] op_r;     // Byte of previous tick
    logic [5:0] gap_exp;  // Expected tick gap
    logic [1:0] hi_a;     // Page group of next address
    assign gap_exp = cki_opt_in == 3'h0 ? 6'h1F : cki_opt_in == 3'h1 ?
                     6'h0F : cki_opt_in == 3'h2 ? 6'h07 : 6'h03;
    assign hi_a = rom_addr_out[9:8] + {1'b0, &rom_addr_out[7:0]};

    // Tick spacing counter
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gap_r  <= 6'h00;
            seen_r <= 1'b0;
        end else begin
            gap_r  <= tick_out ? 6'h00 : gap_r + 6'h01;
            seen_r <= seen_r | tick_out;
        end
    end

    // Byte history for decoding
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_r <= 8'h00;
            op_r <= 8'h00;
        end else begin
            rd_r <= rom_data_in;
            if (tick_out) begin
                op_r <= rd_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_jid_fetch;
        tick_out && rd_r == 8'hFF && !$past(busy_out);
    endsequence
    a_tick_gap: assert property (tick_out && seen_r |-> gap_r == gap_exp)
        else $error("tick spacing off");
    a_we_tick: assert property (acc_we_out |-> tick_out)
        else $error("acc write off tick");
    a_we_pulse: assert property (acc_we_out |=> !acc_we_out)
        else $error("acc write too long");
    a_edge_bits: assert property (acc_we_out && op_r == 8'h33 &&
        rd_r == 8'h29 |-> acc_out[1] == 1'b0 &&
        acc_out[2] == (cko_in_opt_in ? cko_pin_in : 1'b1))
        else $error("edge read bits wrong");
    a_skt_clear: assert property ($fell(tb_flag_out) |->
        $past(tick_out) && $past(rd_r) == 8'h41)
        else $error("flag cleared without test");
    a_flag_tick: assert property ($rose(tb_flag_out) |->
        $past(tick_out)) else $error("flag set off tick");
    a_jid_addr: assert property (s_jid_fetch |-> rom_addr_out ==
        {$past(hi_a), $past(acc_in), $past(ram_digit_in)})
        else $error("indirect address wrong");
    a_q_load: assert property (!$stable(q_out) |-> tick_out &&
        q_out == rd_r) else $error("output latch load wrong");
endmodule : ssq_seq_props

bind ssq_seq ssq_seq_props ssq_seq_props_inst (.*);

/* tb/testbench.sv */
/* Self-checking bench for the sequencer running a ROM program.
   Assumes the package, ROM model and checker are compiled first. */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    err_total++; $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
    end end

module testbench
    import ssq_pkg::*;
;
    logic       clk_in, nrst_in, cko_in_opt_in, cko_pin_in, carry_in;
    logic       ser_shift_in, ser_sclk_en_in, ser_in, in0_in, in3_in;
    logic       skip_in, two_byte_in, acc_we_out, sclk_out, ser_out;
    logic       tb_flag_out, tick_out, busy_out;
    logic [2:0] cki_opt_in;                 // Clock option
    logic [3:0] acc_in, ram_digit_in, acc_out;
    logic [7:0] rom_data_in, q_out;         // ROM byte, output latch
    logic [9:0] rom_addr_out, pc_out;       // Addresses
    int         err_total, checked, m;      // Counters

    ssq_seq #(.TB_DIV(8)) ssq_seq_inst (.*);
    ssq_rom_model ssq_rom_model_inst (.addr_in(rom_addr_out),
                                      .data_out(rom_data_in));

    // Clock and serial data toggling
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    always @(negedge clk_in) ser_in <= (ser_in !== 1'b1);

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // Ticks until address a is fetched, or with fl a fresh overflow
    task automatic tcount(input logic [9:0] a, input bit fl, output int n);
        int i;
        bit z;
        n = 0;
        z = 1'b0;
        for (i = 0; i < 900; i++) begin
            @(negedge clk_in);
            n += int'(tick_out === 1'b1);
            z |= tb_flag_out === 1'b0;
            if (fl ? z && tb_flag_out === 1'b1 : rom_addr_out === a) break;
        end
        if (i == 900) begin
            err_total++;
            $display("[FAIL] wait for %0h timed out", a);
            print_verdict();
        end
    endtask : tcount

    // Reset held two cycles with new pin options
    task automatic rst(input logic [2:0] o, input logic co, input logic p);
        nrst_in = 1'b0;
        cki_opt_in = o;
        cko_in_opt_in = co;
        cko_pin_in = p;
        repeat (2) @(negedge clk_in);
        nrst_in = 1'b1;
    endtask : rst

    initial begin
        {acc_in, ram_digit_in} = 8'h5A;
        {carry_in, ser_shift_in, ser_sclk_en_in} = 3'h5;
        {in0_in, in3_in, skip_in, two_byte_in} = 4'hC;
        err_total = 0;
        checked = 0;
        rst(3'h2, 1'b1, 1'b1);
        tcount(10'h003, 0, m);
        `CHK("edge we", 1'b1, acc_we_out)
        `CHK("edge acc", 4'h4, acc_out)
        tcount(10'h004, 0, m);
        tcount(10'h005, 0, m);
        `CHK("table ticks", 2, m)
        `CHK("table q", 8'hC3, q_out)
        tcount(10'h0C3, 0, m);
        `CHK("jump ticks", 2, m)
        tcount(10'h0C4, 0, m);
        `CHK("jump pc", 10'h0C3, pc_out)
        `CHK("xchg old", 4'h0, acc_out)
        tcount(10'h0C5, 0, m);
        `CHK("xchg new", 4'h5, acc_out)
        tcount(10'h0C6, 0, m);
        tcount(10'h0C7, 0, m);
        `CHK("skip ticks", 1, m)
        `CHK("flag clear", 1'b0, tb_flag_out)
        `CHK("skip busy", 1'b1, busy_out)
        tcount(10'h000, 1, m);
        tcount(10'h000, 1, m);
        `CHK("base period", 8, m)
        `CHK("sclk idle", 1'b0, sclk_out)
        `CHK("sdata idle", 1'b0, ser_out)
        in0_in = 1'b0;
        repeat (40) @(negedge clk_in);
        in0_in = 1'b1;
        repeat (40) @(negedge clk_in);
        $display("test 1 done");
        rst(3'h1, 1'b0, 1'b0);
        tcount(10'h003, 0, m);
        `CHK("kept latch", 4'h5, acc_out)
        in3_in = 1'b0;
        repeat (4) @(negedge clk_in);
        in3_in = 1'b1;
        repeat (64) @(negedge clk_in);
        $display("test 2 done");
        rst(3'h3, 1'b1, 1'b0);
        tcount(10'h003, 0, m);
        `CHK("cleared latch", 4'h0, acc_out)
        $display("test 3 done");
        print_verdict();
    end
endmodule : testbench
